// ==== logic/wei_consts.vh ====
// Constants for the wake-up event indicator block: offsets, fields, power states and timing.
`ifndef WEI_CONSTS_VH
`define WEI_CONSTS_VH

// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define WEI_OFF_PMC        8'h84
`define WEI_OFF_BYTE_TEST  8'h64
`define WEI_BYTE_TEST_VAL  32'h5a3c_96e1

// ****************************************
// Field positions in power_mgmt_control
// ****************************************
`define WEI_BIT_READY      0
`define WEI_BIT_OUT_EN     1
`define WEI_BIT_POL        2
`define WEI_BIT_STYLE      3
`define WEI_CAUSE_LSB      4
`define WEI_CAUSE_MSB      5
`define WEI_BIT_TYPE       6
`define WEI_BIT_ENERGY_WAKE_ENABLE      8
`define WEI_BIT_FRAME_WAKE_ENABLE     9
`define WEI_MODE_LSB       12
`define WEI_MODE_MSB       13

// ****************************************
// Power state encodings
// ****************************************
`define WEI_MODE_D0        2'h0
`define WEI_MODE_D1        2'h1
`define WEI_MODE_D2        2'h2
`define WEI_MODE_RSVD      2'h3

// ****************************************
// Timing
// ****************************************
`define WEI_CLK_KHZ        100000
`define WEI_PULSE_MS       50
`define WEI_PULSE_CYCLES   (`WEI_PULSE_MS * `WEI_CLK_KHZ)
`define WEI_STABLE_US      10
`define WEI_STABLE_CYCLES  (`WEI_STABLE_US * `WEI_CLK_KHZ / 1000)

`endif

// ==== logic/wei_wakeup_indicator.v ====
// Wake-up cause recording, wake indicator pin driver and device-ready sequencing.
//
// Functional notes
// - Cause field: 00 none, 01 energy, 10 frame, 11 both
// - Writing one clears a cause bit
// - Cause clears only in D0 with ready
// - Cause bit holds while its source pends
// - Pulsed style drives 50 ms pulse per event
// - Static style holds indicator after event
// - Clearing cause or enable drops indicator
// - Polarity bit: high when set, low clear
// - Open-drain ignores polarity, always active low
// - Pin driven only when output enable set
// - Output enable never affects wake interrupt
// - Control register readable in every state
// - Ready only after stabilising from power-up/sleep
// - Mode 00 D0, 01 D1, 10 D2; 11 forbidden
// - Enabled event raises interrupt, drives pin if enabled
// - Driver type: clear open-drain, set push-pull
// - Byte test write wakes from reduced power

`include "wei_consts.vh"

module wei_wakeup_indicator #(
	parameter integer PULSE_CYCLES = `WEI_PULSE_CYCLES
)(
	input  wire        clk,
	input  wire        rst_n,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr_en,
	input  wire        rd_en,
	output reg  [31:0] rdata,
	input  wire        energy_detect_in,
	input  wire        frame_wake_event,
	input  wire        energy_src_pending,
	input  wire        frame_src_pending,
	output wire        wake_indicator_pin_o,
	output wire        wake_indicator_pin_oe_n,
	output reg         wake_interrupt_flag,
	output wire [1:0]  power_state_select,
	output wire        device_ready
);

	// ****************************************
	// Local constants and states
	// ****************************************
	localparam [1:0]  ST_SETTLE = 2'h0;
	localparam [1:0]  ST_READY  = 2'h1;
	localparam [1:0]  ST_SLEEP  = 2'h2;
	localparam [22:0] PULSE_LOAD = PULSE_CYCLES[22:0];
	localparam integer STABLE_CYCLES = `WEI_STABLE_CYCLES;
	localparam [15:0] STABLE_LOAD = STABLE_CYCLES[15:0];

	// Address match, used by both the write and the read decode
	function hit;
		input [7:0] a;
		input [7:0] off;
		begin
			hit = (a == off);
		end
	endfunction

	// ****************************************
	// State
	// ****************************************
	reg [1:0]  state_reg;
	reg [1:0]  state_next;
	reg [15:0] settle_cnt_reg;
	reg [15:0] settle_cnt_next;
	reg [1:0]  mode_reg;
	reg [1:0]  mode_next;
	reg        frame_wake_enable_reg;
	reg        energy_wake_enable_reg;
	reg        type_reg;
	reg        style_reg;
	reg        pol_reg;
	reg        out_en_reg;
	reg [1:0]  cause_reg;
	reg [1:0]  cause_next;
	reg [22:0] pulse_cnt_reg;
	reg [22:0] pulse_cnt_next;
	reg        static_reg;
	reg        static_next;
	reg        ed_sync1_reg;
	reg        ed_sync2_reg;
	reg        ed_prev_reg;

	wire       ready;
	wire       wr_pmc;
	wire       wr_byte_test;
	wire       energy_evt;
	wire [1:0] cause_set;
	wire [1:0] cause_clr;
	wire       qual_evt;
	wire       keep;
	wire       ind_active;

	assign ready = (state_reg == ST_READY);
	assign device_ready = ready;
	assign power_state_select = mode_reg;

	// ****************************************
	// Energy detect input synchroniser
	// ****************************************
	// The detector sits in the analog front end, so it is treated as asynchronous.
	// Edge detection looks at the second stage only.
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			ed_sync1_reg <= 1'b0;
			ed_sync2_reg <= 1'b0;
			ed_prev_reg  <= 1'b0;
		end
		else
		begin
			ed_sync1_reg <= energy_detect_in;
			ed_sync2_reg <= ed_sync1_reg;
			ed_prev_reg  <= ed_sync2_reg;
		end
	end

	assign energy_evt = ed_sync2_reg & ~ed_prev_reg;

	// ****************************************
	// Bus decode
	// ****************************************
	// Writes to the control register are only honoured once ready; the host is
	// expected to wait anyway, and dropping them keeps a sleeping core consistent.
	assign wr_pmc       = wr_en & hit(addr, `WEI_OFF_PMC) & ready;
	// The byte test register holds no state here; a write only wakes the core
	assign wr_byte_test = wr_en & hit(addr, `WEI_OFF_BYTE_TEST);

	// ****************************************
	// Wake events and cause field
	// ****************************************
	assign cause_set[0] = energy_evt & energy_wake_enable_reg;
	assign cause_set[1] = frame_wake_event & frame_wake_enable_reg;
	assign qual_evt     = |cause_set;

	// Clear needs a one in that position, D0 and ready, and a quiet source
	assign cause_clr[0] = wr_pmc & wdata[`WEI_CAUSE_LSB] & (mode_reg == `WEI_MODE_D0)
	                      & ~energy_src_pending;
	assign cause_clr[1] = wr_pmc & wdata[`WEI_CAUSE_MSB] & (mode_reg == `WEI_MODE_D0)
	                      & ~frame_src_pending;

	// A new event in the clearing cycle wins over the clear
	always @*
	begin
		cause_next = cause_set | (cause_reg & ~cause_clr);
	end

	// ****************************************
	// Indicator timing
	// ****************************************
	// The indicator stays alive only while a set cause bit still has its enable
	assign keep = (cause_reg[0] & energy_wake_enable_reg) | (cause_reg[1] & frame_wake_enable_reg);

	always @*
	begin
		pulse_cnt_next = pulse_cnt_reg;
		static_next    = static_reg;
		if (qual_evt)
		begin
			// Every new event restarts the pulse in full
			pulse_cnt_next = style_reg ? PULSE_LOAD : 23'h0;
			static_next    = ~style_reg;
		end
		else if (!keep)
		begin
			pulse_cnt_next = 23'h0;
			static_next    = 1'b0;
		end
		else if (pulse_cnt_reg != 23'h0)
		begin
			pulse_cnt_next = pulse_cnt_reg - 23'h1;
		end
	end

	// Set bits are only visible from the cycle after the event, so the keep test
	// is bypassed while the event itself is being recorded.
	assign ind_active = (pulse_cnt_reg != 23'h0) | static_reg;

	// ****************************************
	// Pin driver
	// ****************************************
	// Open-drain pulls low only while active; push-pull follows polarity.
	// The open-drain pin never drives high, so the board needs a pull-up.
	assign wake_indicator_pin_o    = type_reg ? (pol_reg ? ind_active : ~ind_active)
	                                          : 1'b0;
	assign wake_indicator_pin_oe_n = type_reg ? ~out_en_reg
	                                          : ~(out_en_reg & ind_active);

	// ****************************************
	// Power state sequencer
	// ****************************************
	// Settle counts down after reset and after every wake before ready is raised.
	// Events whose enable is clear never wake a sleeping core.
	always @*
	begin
		state_next      = state_reg;
		settle_cnt_next = settle_cnt_reg;
		mode_next       = mode_reg;
		case (state_reg)
			ST_SETTLE:
			begin
				if (settle_cnt_reg == 16'h0)
				begin
					state_next = ST_READY;
				end
				else
				begin
					settle_cnt_next = settle_cnt_reg - 16'h1;
				end
			end
			ST_READY:
			begin
				// The reserved code is dropped and the mode kept
				if (wr_pmc && (wdata[`WEI_MODE_MSB:`WEI_MODE_LSB] != `WEI_MODE_RSVD)
				    && (wdata[`WEI_MODE_MSB:`WEI_MODE_LSB] != `WEI_MODE_D0))
				begin
					mode_next  = wdata[`WEI_MODE_MSB:`WEI_MODE_LSB];
					state_next = ST_SLEEP;
				end
			end
			ST_SLEEP:
			begin
				// Mode bits clear themselves on the way back to D0
				if (wr_byte_test || qual_evt)
				begin
					mode_next       = `WEI_MODE_D0;
					settle_cnt_next = STABLE_LOAD;
					state_next      = ST_SETTLE;
				end
			end
			default:
			begin
				state_next      = ST_SETTLE;
				settle_cnt_next = STABLE_LOAD;
				mode_next       = `WEI_MODE_D0;
			end
		endcase
	end

	// ****************************************
	// Registers
	// ****************************************
	// Control fields change only through an accepted control write
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg      <= ST_SETTLE;
			settle_cnt_reg <= STABLE_LOAD;
			mode_reg       <= `WEI_MODE_D0;
			frame_wake_enable_reg     <= 1'b0;
			energy_wake_enable_reg      <= 1'b0;
			type_reg       <= 1'b0;
			style_reg      <= 1'b0;
			pol_reg        <= 1'b0;
			out_en_reg     <= 1'b0;
			cause_reg      <= 2'h0;
			pulse_cnt_reg  <= 23'h0;
			static_reg     <= 1'b0;
		end
		else
		begin
			state_reg      <= state_next;
			settle_cnt_reg <= settle_cnt_next;
			mode_reg       <= mode_next;
			cause_reg      <= cause_next;
			pulse_cnt_reg  <= pulse_cnt_next;
			static_reg     <= static_next;
			if (wr_pmc)
			begin
				frame_wake_enable_reg <= wdata[`WEI_BIT_FRAME_WAKE_ENABLE];
				energy_wake_enable_reg  <= wdata[`WEI_BIT_ENERGY_WAKE_ENABLE];
				type_reg   <= wdata[`WEI_BIT_TYPE];
				style_reg  <= wdata[`WEI_BIT_STYLE];
				pol_reg    <= wdata[`WEI_BIT_POL];
				out_en_reg <= wdata[`WEI_BIT_OUT_EN];
			end
		end
	end

	// ****************************************
	// Wake interrupt
	// ****************************************
	// One-cycle pulse for the interrupt controller; the pin enable plays no part.
	// Stickiness is left to the interrupt controller, which saves a clear path here.
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			wake_interrupt_flag <= 1'b0;
		end
		else
		begin
			wake_interrupt_flag <= qual_evt;
		end
	end

	// ****************************************
	// Read path
	// ****************************************
	// Control register answers in every power state, even while not ready.
	// Loading zero outside a read cycle keeps stale answers off the bus.
	always @(posedge clk)
	begin
		if (!rst_n)
		begin
			rdata <= 32'h0;
		end
		else if (rd_en && hit(addr, `WEI_OFF_PMC))
		begin
			rdata                                <= 32'h0;
			rdata[`WEI_MODE_MSB:`WEI_MODE_LSB]   <= mode_reg;
			rdata[`WEI_BIT_FRAME_WAKE_ENABLE]               <= frame_wake_enable_reg;
			rdata[`WEI_BIT_ENERGY_WAKE_ENABLE]                <= energy_wake_enable_reg;
			rdata[`WEI_BIT_TYPE]                 <= type_reg;
			rdata[`WEI_CAUSE_MSB:`WEI_CAUSE_LSB] <= cause_reg;
			rdata[`WEI_BIT_STYLE]                <= style_reg;
			rdata[`WEI_BIT_POL]                  <= pol_reg;
			rdata[`WEI_BIT_OUT_EN]               <= out_en_reg;
			rdata[`WEI_BIT_READY]                <= ready;
		end
		else if (rd_en && hit(addr, `WEI_OFF_BYTE_TEST))
		begin
			rdata <= `WEI_BYTE_TEST_VAL;
		end
		else
		begin
			// Unmapped reads and idle cycles return zero
			rdata <= 32'h0;
		end
	end

endmodule // wei_wakeup_indicator

// ==== test/wei_assertions.sv ====
// Port-level assertions for the wake-up indicator block.
`include "wei_consts.vh"
module wei_assertions (
	input wire        clk,
	input wire        rst_n,
	input wire [7:0]  addr,
	input wire [31:0] wdata,
	input wire        wr_en,
	input wire        rd_en,
	input wire [31:0] rdata,
	input wire        energy_detect_in,
	input wire        frame_wake_event,
	input wire        energy_src_pending,
	input wire        frame_src_pending,
	input wire        wake_indicator_pin_o,
	input wire        wake_indicator_pin_oe_n,
	input wire        wake_interrupt_flag,
	input wire [1:0]  power_state_select,
	input wire        device_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ****************************************
	// Checks
	// ****************************************
	logic [10:0] settle_cnt;
	wire         pmc_wr = wr_en && addr == `WEI_OFF_PMC && device_ready;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Cycles spent in D0 not yet ready; slack of a few cycles for reset release
	always_ff @(posedge clk)
		if (!rst_n || device_ready || power_state_select != `WEI_MODE_D0)
			settle_cnt <= 11'h0;
		else if (settle_cnt != 11'h7ff)
			settle_cnt <= settle_cnt + 11'h1;

	a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
		else $error("read data not zero outside answer cycle");
	a_read_state: assert property (rd_en && addr == `WEI_OFF_PMC |=>
		rdata[0] == $past(device_ready) && rdata[13:12] == $past(power_state_select))
		else $error("control read disagrees with ready or mode");
	a_int_cause: assert property (wake_interrupt_flag |-> $past(frame_wake_event) ||
		$past(energy_detect_in, 2) || $past(energy_detect_in, 3) || $past(energy_detect_in, 4))
		else $error("interrupt without event");
	a_ready_d0: assert property (device_ready |-> power_state_select == `WEI_MODE_D0)
		else $error("ready outside D0");
	a_ready_settle: assert property ($rose(device_ready) |-> settle_cnt >= 11'h3e6)
		else $error("ready came too early");
	a_mode_legal: assert property (power_state_select != `WEI_MODE_RSVD)
		else $error("reserved mode reached");
	a_sleep_entry: assert property (pmc_wr && wdata[13:12] == `WEI_MODE_D1 |=>
		power_state_select == `WEI_MODE_D1 && !device_ready)
		else $error("sleep entry wrong");
	a_wake_write: assert property (wr_en && addr == `WEI_OFF_BYTE_TEST &&
		power_state_select != `WEI_MODE_D0 |=> (power_state_select == `WEI_MODE_D0 && !device_ready) [*8])
		else $error("wake write did not wake");
	a_oe_off: assert property (pmc_wr && !wdata[1] |=> wake_indicator_pin_oe_n)
		else $error("pin driven with output enable clear");
	a_od_low: assert property (pmc_wr && !wdata[6] |=> !wake_indicator_pin_o)
		else $error("open-drain output not low");
endmodule // wei_assertions

bind wei_wakeup_indicator wei_assertions wei_assertions_i (.clk, .rst_n, .addr, .wdata, .wr_en, .rd_en,
	.rdata, .energy_detect_in, .frame_wake_event, .energy_src_pending, .frame_src_pending,
	.wake_indicator_pin_o, .wake_indicator_pin_oe_n, .wake_interrupt_flag, .power_state_select, .device_ready);

// ==== test/wei_host_model.sv ====
// Host processor model: register cycles and ready polling.
`include "wei_consts.vh"
module wei_host_model (
	input wire logic         clk,
	output logic [7:0]       addr,
	output logic [31:0]      wdata,
	output logic             wr_en,
	output logic             rd_en,
	input wire logic [31:0]  rdata
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [31:0] exp_q[$];

	// Idle bus from time zero
	initial
	begin
		addr = 8'h0;
		wdata = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
	end

	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask

	// One-cycle read strobe; expected answer noted for the monitor
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask

	// Only the control register is touched until ready reads set
	task poll(output bit ok);
		ok = 1'b0;
		repeat (1500)
		begin
			@(posedge clk);
			addr <= `WEI_OFF_PMC;
			rd_en <= 1'b1;
			@(posedge clk);
			rd_en <= 1'b0;
			@(negedge clk);
			if (rdata[0] === 1'b1)
			begin
				ok = 1'b1;
				return;
			end
		end
	endtask
endmodule // wei_host_model

// ==== test/wei_wakeup_indicator_test.sv ====
// Self-checking bench for the wake-up indicator block.
`include "wei_consts.vh"
module wei_wakeup_indicator_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk, rst_n, ed_in, fw_ev, ed_pend, fw_pend, rd_q;
	logic [7:0]  addr;
	logic [31:0] wdata, rdata, v;
	logic        wr_en, rd_en, pin_o, pin_oe_n, irq, rdy;
	logic [1:0]  mode;
	int          fails, samples_checked, cyc;
	bit          ok;

	wei_wakeup_indicator #(.PULSE_CYCLES(20)) wei_wakeup_indicator_i (.clk(clk), .rst_n(rst_n), .addr(addr),
		.wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .energy_detect_in(ed_in),
		.frame_wake_event(fw_ev), .energy_src_pending(ed_pend), .frame_src_pending(fw_pend),
		.wake_indicator_pin_o(pin_o), .wake_indicator_pin_oe_n(pin_oe_n), .wake_interrupt_flag(irq),
		.power_state_select(mode), .device_ready(rdy));
	wei_host_model wei_host_model_i (.clk(clk), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
		.rdata(rdata));

	// ****************************************
	// Helpers
	// ****************************************
	task chk(input bit good, input string what);
		samples_checked++;
		if (!good)
		begin
			fails++;
			$display("ERROR at %0t: %s", $time, what);
		end
	endtask

	task print_verdict();
		$display("comparisons %0d, mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		wei_host_model_i.wr(a, d);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e);
		wei_host_model_i.rd(a, e);
	endtask

	// Frame event; interrupt must pulse whatever the output enable says
	task fev();
		@(posedge clk);
		fw_ev <= 1'b1;
		@(posedge clk);
		fw_ev <= 1'b0;
		@(negedge clk);
		chk(irq === 1'b1, "no interrupt pulse");
	endtask

	// Pin sampled mid-cycle, away from register updates
	task pin(input logic o, input logic oe_n);
		@(negedge clk);
		chk(pin_o === o && pin_oe_n === oe_n, "pin level");
	endtask

	// Clock and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk)
	begin
		rd_q <= rd_en;
		cyc++;
		if (cyc == 20000)
		begin
			fails++;
			print_verdict();
		end
	end

	// Read answers compared with the oldest noted value
	always @(negedge clk)
		if (rd_q === 1'b1 && wei_host_model_i.exp_q.size() != 0)
			chk(rdata === wei_host_model_i.exp_q.pop_front(), "read data");

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		rst_n = 1'b0;
		ed_in = 1'b0;
		fw_ev = 1'b0;
		ed_pend = 1'b0;
		fw_pend = 1'b0;
		v = $urandom(11);
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		wei_host_model_i.poll(ok);
		chk(ok && rdy === 1'b1, "not ready after reset");
		wr(`WEI_OFF_PMC, 32'h346);
		rd(`WEI_OFF_PMC, 32'h347);
		rd(8'h10, 32'h0);
		wr(`WEI_OFF_PMC, 32'h3346);
		rd(`WEI_OFF_PMC, 32'h347);
		$display("test config done");
		fw_pend <= 1'b1;
		fev();
		pin(1'b1, 1'b0);
		rd(`WEI_OFF_PMC, 32'h367);
		ed_in <= 1'b1;
		repeat (6) @(posedge clk);
		ed_in <= 1'b0;
		rd(`WEI_OFF_PMC, 32'h377);
		wr(`WEI_OFF_PMC, 32'h376);
		rd(`WEI_OFF_PMC, 32'h367);
		fw_pend <= 1'b0;
		wr(`WEI_OFF_PMC, 32'h366);
		rd(`WEI_OFF_PMC, 32'h347);
		pin(1'b0, 1'b0);
		$display("test static done");
		wr(`WEI_OFF_PMC, 32'h20e);
		fev();
		pin(1'b0, 1'b0);
		repeat (10) @(posedge clk);
		fev();
		repeat (15) @(posedge clk);
		pin(1'b0, 1'b0);
		repeat (8) @(posedge clk);
		pin(1'b0, 1'b1);
		wr(`WEI_OFF_PMC, 32'h242);
		fev();
		pin(1'b0, 1'b0);
		wr(`WEI_OFF_PMC, 32'h262);
		// The indicator drops one cycle after the cause bit clears
		@(posedge clk);
		pin(1'b1, 1'b0);
		wr(`WEI_OFF_PMC, 32'h208);
		fev();
		pin(1'b0, 1'b1);
		wr(`WEI_OFF_PMC, 32'h228);
		$display("test pulse done");
		for (int m = 1; m < 3; m++)
		begin
			v = 32'h346 | (32'(m) << 12);
			wr(`WEI_OFF_PMC, v);
			rd(`WEI_OFF_PMC, v);
			wr(`WEI_OFF_BYTE_TEST, $urandom());
			rd(`WEI_OFF_PMC, 32'h346);
			wei_host_model_i.poll(ok);
			chk(ok, "no wake");
			rd(`WEI_OFF_PMC, 32'h347);
		end
		$display("test sleep done");
		// A frame event wakes a sleeping core and leaves its cause behind
		wr(`WEI_OFF_PMC, 32'h2346);
		fev();
		rd(`WEI_OFF_PMC, 32'h366);
		wei_host_model_i.poll(ok);
		chk(ok, "no event wake");
		// A pending energy source keeps its cause bit through a clear
		@(posedge clk);
		ed_pend <= 1'b1;
		ed_in <= 1'b1;
		repeat (4) @(posedge clk);
		wr(`WEI_OFF_PMC, 32'h376);
		rd(`WEI_OFF_PMC, 32'h357);
		ed_in <= 1'b0;
		ed_pend <= 1'b0;
		wr(`WEI_OFF_PMC, 32'h356);
		rd(`WEI_OFF_PMC, 32'h347);
		$display("test wake event done");
		print_verdict();
	end
endmodule // wei_wakeup_indicator_test
